// ===== dv/tb_top.sv
// Testbench: control register, vector move, scan port and pin interrupts
`timescale 1ns/1ps
module tb_top;
  import vspi_pkg::*;
  localparam logic [7:0] GEN = VSPI_OFF_GENERAL;
  localparam logic [7:0] FLG = VSPI_OFF_IRQ_FLAG;
  logic clk_i = 1'h0, rstn_i = 1'h0, wr_en_i = 1'h0, rd_en_i = 1'h0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
  logic io_clk_run_i = 1'h1, global_irq_enable_i = 1'h1;
  logic exec_in_boot_i = 1'h0, scan_port_fuse_i = 1'h1, ack_en = 1'h0;
  logic app_section_lock_bit_i = 1'h0, boot_section_lock_bit_i = 1'h0;
  logic [7:0] pin_direction_bit_i = 8'h00, pin_output_bit_i = 8'h00;
  logic [7:0] irq_lvl = 8'hff, o, n, m0, e;
  logic [8:0] chg_lvl = 9'h000, t, pin_change_inputs_i;
  logic [7:0] rdata_o, dedicated_irq_pins_i, ext_irq_ack_i, ext_irq_req_o;
  logic [1:0] pin_change_req_o, code;
  logic irq_blocked_o, vector_table_select_o, scan_port_enable_o;
  logic pullup_global_off_o, io, wake_o;
  logic [7:0] pullup_enable_o;
  int error_cnt = 0, comparisons = 0;
  // Clock: 25 ns period
  always #12.5 clk_i = ~clk_i;
  vspi_ctrl #(.NPORT(8)) i_vspi_ctrl (.clk_i, .rstn_i, .addr_i, .wdata_i,
    .wr_en_i, .rd_en_i, .rdata_o, .dedicated_irq_pins_i,
    .pin_change_inputs_i, .io_clk_run_i, .global_irq_enable_i,
    .exec_in_boot_i, .app_section_lock_bit_i, .boot_section_lock_bit_i,
    .scan_port_fuse_i, .pin_direction_bit_i, .pin_output_bit_i,
    .ext_irq_ack_i, .pin_change_ack_i(2'h0), .ext_irq_req_o,
    .pin_change_req_o, .irq_blocked_o, .wake_o, .vector_table_select_o,
    .scan_port_enable_o, .pullup_global_off_o, .pullup_enable_o);
  vspi_pad_model i_vspi_pad_model (.clk_i, .irq_lvl_i(irq_lvl),
    .chg_lvl_i(chg_lvl), .ack_en_i(ack_en), .req_i(ext_irq_req_o),
    .pins_o(dedicated_irq_pins_i), .chg_o(pin_change_inputs_i),
    .ack_o(ext_irq_ack_i));
  // Expected edge flags; the upper four need the I/O clock
  function automatic logic [7:0] exp_flag(input logic [1:0] c,
    input logic [7:0] a, b, input logic run);
    logic [7:0] f;
    case (c)
      VSPI_SENSE_ANY: f = a ^ b;
      VSPI_SENSE_FALL: f = a & ~b;
      VSPI_SENSE_RISE: f = ~a & b;
      default: f = 8'h00;
    endcase
    if (!run)
      f[7:4] = 4'h0;
    return f;
  endfunction : exp_flag
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One bus cycle: op 2 writes, 1 reads, 0 idles; strobe drops next call
  task automatic bus(input logic [1:0] op, input logic [7:0] a, d);
    wr_en_i <= op[1];
    rd_en_i <= op[0];
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    #1;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus(2'h1, a, 8'h00);
    chk(rdata_o, exp);
  endtask : rd
  // Idle cycles, with pin direction and output bits shuffled
  task automatic idle(input int k);
    repeat (k)
    begin
      pin_direction_bit_i <= 8'($urandom);
      pin_output_bit_i <= 8'($urandom);
      bus(2'h0, 8'h00, 8'h00);
    end
  endtask : idle
  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // Watchdog: the tests need well under a thousand cycles
  initial
  begin
    repeat (4000) @(posedge clk_i);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(1));
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'h1;
    rd(GEN, VSPI_RST_BYTE);
    bus(2'h2, GEN, 8'hff);
    chk({7'h0, irq_blocked_o}, 8'h01);
    rd(GEN, 8'h11);
    idle(4);
    chk(pullup_enable_o, 8'h00);
    chk({7'h0, pullup_global_off_o}, 8'h01);
    rd(GEN, 8'h10);
    bus(2'h2, 8'h00, 8'hff);
    rd(8'h00, 8'h00);
    $display("test registers done");
    bus(2'h2, GEN, 8'h01);
    bus(2'h2, GEN, 8'h02);
    chk({7'h0, vector_table_select_o}, 8'h01);
    chk({7'h0, irq_blocked_o}, 8'h01);
    idle(3);
    chk({7'h0, irq_blocked_o}, 8'h00);
    chk(pullup_enable_o, ~pin_direction_bit_i & pin_output_bit_i);
    chk({7'h0, pullup_global_off_o}, 8'h00);
    bus(2'h2, GEN, 8'h00);
    bus(2'h2, GEN, 8'h01);
    idle(5);
    bus(2'h2, GEN, 8'h00);
    rd(GEN, 8'h02);
    app_section_lock_bit_i <= 1'h1;
    idle(1);
    chk({7'h0, irq_blocked_o}, 8'h01);
    exec_in_boot_i <= 1'h1;
    idle(1);
    chk({7'h0, irq_blocked_o}, 8'h00);
    app_section_lock_bit_i <= 1'h0;
    $display("test vector done");
    bus(2'h2, GEN, 8'h80);
    idle(1);
    chk({7'h0, scan_port_enable_o}, 8'h01);
    bus(2'h2, GEN, 8'h80);
    chk({7'h0, scan_port_enable_o}, 8'h00);
    bus(2'h2, GEN, 8'h00);
    bus(2'h2, GEN, 8'h00);
    chk({7'h0, scan_port_enable_o}, 8'h01);
    scan_port_fuse_i <= 1'h0;
    idle(1);
    chk({7'h0, scan_port_enable_o}, 8'h00);
    scan_port_fuse_i <= 1'h1;
    $display("test scan done");
    bus(2'h2, VSPI_OFF_IRQ_MASK, 8'hff);
    for (int c = 0; c < 4; c++)
    begin
      code = 2'(c);
      io = (c != 2);
      io_clk_run_i <= io;
      bus(2'h2, VSPI_OFF_SENSE_LOW, {4{code}});
      bus(2'h2, VSPI_OFF_SENSE_HIGH, {4{code}});
      bus(2'h2, FLG, 8'hff);
      o = irq_lvl;
      n = (c == 1) ? ~o : 8'($urandom);
      irq_lvl <= n;
      idle(6);
      e = exp_flag(code, o, n, io);
      rd(FLG, e);
      chk(ext_irq_req_o, (c == 0) ? ~n : e);
      if (c == 1)
      begin
        global_irq_enable_i <= 1'h0;
        idle(1);
        chk(ext_irq_req_o, 8'h00);
        global_irq_enable_i <= 1'h1;
        ack_en <= 1'h1;
        idle(3);
        ack_en <= 1'h0;
        rd(FLG, 8'h00);
      end
      bus(2'h2, FLG, 8'hff);
      rd(FLG, 8'h00);
    end
    $display("test pins done");
    io_clk_run_i <= 1'h0;
    m0 = 8'($urandom);
    bus(2'h2, VSPI_OFF_CHG_CTRL, 8'h03);
    bus(2'h2, VSPI_OFF_CHG_MASK0, m0);
    bus(2'h2, VSPI_OFF_CHG_MASK1, 8'h01);
    bus(2'h2, VSPI_OFF_CHG_MASK2, 8'hff);
    rd(VSPI_OFF_CHG_MASK2, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      bus(2'h2, VSPI_OFF_CHG_FLAG, 8'h03);
      t = (k == 0) ? 9'h100 : 9'($urandom);
      chg_lvl <= chg_lvl ^ t;
      idle(6);
      e = {6'h00, t[8], |(t[7:0] & m0)};
      rd(VSPI_OFF_CHG_FLAG, e);
      chk({6'h00, pin_change_req_o}, e);
      chk({7'h00, wake_o}, {7'h00, |e});
    end
    idle(2);
    $display("test change done");
    print_verdict();
  end
endmodule : tb_top

// ===== dv/vspi_ctrl_monitor.sv
// Checker: port-level properties of the vector select block
`timescale 1ns/1ps
module vspi_ctrl_monitor
  import vspi_pkg::*;
#(
  parameter int NPORT = 8  // Port pins with pull-up control
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [7:0] rdata_o,
  input wire logic exec_in_boot_i,
  input wire logic app_section_lock_bit_i,
  input wire logic boot_section_lock_bit_i,
  input wire logic scan_port_fuse_i,
  input wire logic [NPORT-1:0] pin_direction_bit_i,
  input wire logic [NPORT-1:0] pin_output_bit_i,
  input wire logic irq_blocked_o,
  input wire logic vector_table_select_o,
  input wire logic scan_port_enable_o,
  input wire logic pullup_global_off_o,
  input wire logic [NPORT-1:0] pullup_enable_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Shared decode: general register write, unlock write, scan bit
  logic gw;
  logic uw;
  logic sd;
  logic nolock;
  assign gw = wr_en_i && (addr_i == VSPI_OFF_GENERAL);
  assign uw = gw && wdata_i[VSPI_BIT_UNLOCK];
  assign sd = wdata_i[VSPI_BIT_SCANDIS];
  assign nolock = !app_section_lock_bit_i && !boot_section_lock_bit_i;
  property p_rd_idle;
    !$past(rd_en_i) |-> rdata_o == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside its slot");
  property p_blk_on;
    uw |=> irq_blocked_o [*2];
  endproperty
  a_blk_on: assert property (p_blk_on)
    else $error("unlock did not block interrupts");
  // Without a select write the block must end after four cycles
  property p_blk_off;
    uw ##1 (!gw && nolock) [*4] ##1 nolock |-> !irq_blocked_o;
  endproperty
  a_blk_off: assert property (p_blk_off)
    else $error("interrupt block overstays");
  property p_vsel;
    $changed(vector_table_select_o) && $past(rstn_i) |->
      $past(gw) && !$past(uw);
  endproperty
  a_vsel: assert property (p_vsel)
    else $error("select changed without a select write");
  property p_scan;
    $changed(scan_port_enable_o) && $stable(scan_port_fuse_i) &&
      $past(rstn_i) |-> $past(gw) && (scan_port_enable_o == !$past(sd));
  endproperty
  a_scan: assert property (p_scan)
    else $error("scan enable changed without a write");
  property p_fuse;
    !scan_port_fuse_i |-> !scan_port_enable_o;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("scan port enabled without fuse");
  property p_pull;
    pullup_enable_o == (~pin_direction_bit_i & pin_output_bit_i &
      {NPORT{!pullup_global_off_o}});
  endproperty
  a_pull: assert property (p_pull)
    else $error("pull-up enable wrong");
  property p_lock;
    (vector_table_select_o && app_section_lock_bit_i && !exec_in_boot_i) ||
      (!vector_table_select_o && boot_section_lock_bit_i && exec_in_boot_i)
      |-> irq_blocked_o;
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock bit did not block interrupts");
  c_vsel: cover property ($rose(vector_table_select_o));
  c_scan: cover property ($fell(scan_port_enable_o));
  c_puoff: cover property ($rose(pullup_global_off_o));
endmodule : vspi_ctrl_monitor

bind vspi_ctrl vspi_ctrl_monitor #(.NPORT(NPORT)) i_vspi_ctrl_monitor (
  .clk_i, .rstn_i, .addr_i, .wdata_i, .wr_en_i, .rd_en_i, .rdata_o,
  .exec_in_boot_i, .app_section_lock_bit_i, .boot_section_lock_bit_i,
  .scan_port_fuse_i, .pin_direction_bit_i, .pin_output_bit_i,
  .irq_blocked_o, .vector_table_select_o, .scan_port_enable_o,
  .pullup_global_off_o, .pullup_enable_o);

// ===== dv/vspi_pad_model.sv
// Partner model: pin pads and the core taking pin vectors
`timescale 1ns/1ps
module vspi_pad_model
(
  input wire logic clk_i,
  input wire logic [7:0] irq_lvl_i,
  input wire logic [8:0] chg_lvl_i,
  input wire logic ack_en_i,
  input wire logic [7:0] req_i,
  output logic [7:0] pins_o,
  output logic [8:0] chg_o,
  output logic [7:0] ack_o
);
  // Pads start idle high, change-inputs low, no acknowledge
  initial
  begin
    pins_o = 8'hff;
    chg_o = 9'h000;
    ack_o = 8'h00;
  end
  // Pads follow asked levels one edge later, even when driven as outputs
  always @(posedge clk_i)
  begin
    pins_o <= irq_lvl_i;
    chg_o <= chg_lvl_i;
    // Core takes each pending vector once, a one-cycle pulse
    ack_o <= ack_en_i ? (req_i & ~ack_o) : 8'h00;
  end
endmodule : vspi_pad_model

// ===== inc/vspi_pkg.sv
// Package: register map, field positions and timing counts of the block
package vspi_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] VSPI_OFF_GENERAL = 8'h35;
  localparam logic [7:0] VSPI_OFF_SENSE_LOW = 8'h69;
  localparam logic [7:0] VSPI_OFF_SENSE_HIGH = 8'h6a;
  localparam logic [7:0] VSPI_OFF_IRQ_MASK = 8'h3d;
  localparam logic [7:0] VSPI_OFF_IRQ_FLAG = 8'h3c;
  localparam logic [7:0] VSPI_OFF_CHG_CTRL = 8'h68;
  localparam logic [7:0] VSPI_OFF_CHG_FLAG = 8'h3b;
  localparam logic [7:0] VSPI_OFF_CHG_MASK0 = 8'h6b;
  localparam logic [7:0] VSPI_OFF_CHG_MASK1 = 8'h6c;
  localparam logic [7:0] VSPI_OFF_CHG_MASK2 = 8'h6d;

  // ------------------------------------------------------------------
  // General control register fields
  // ------------------------------------------------------------------
  localparam int VSPI_BIT_UNLOCK = 0;
  localparam int VSPI_BIT_VSEL = 1;
  localparam int VSPI_BIT_PUOFF = 4;
  localparam int VSPI_BIT_SCANDIS = 7;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] VSPI_RST_BYTE = 8'h00;
  localparam logic [15:0] VSPI_RST_SENSE = 16'h0000;

  // ------------------------------------------------------------------
  // Timing counts in system clock cycles
  // ------------------------------------------------------------------
  localparam logic [2:0] VSPI_WIN_CYCLES = 3'h4;  // Timed sequence window
  localparam logic [2:0] VSPI_POST_SEL = 3'h2;  // Write plus next instr

  // ------------------------------------------------------------------
  // Sense select encodings
  // ------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    VSPI_SENSE_LOW = 2'h0,
    VSPI_SENSE_ANY = 2'h1,
    VSPI_SENSE_FALL = 2'h2,
    VSPI_SENSE_RISE = 2'h3
  } vspi_sense_t;

endpackage : vspi_pkg

// ===== rtl/vspi_ctrl.sv
// Vector select, scan port disable, pull-up disable and pin interrupts
`timescale 1ns/1ps

// How it works
// [R1] Select bit places vector table flash/boot
// [R2] Select changes only after unlock within four
// [R3] Block interrupts from unlock until after select
// [R4] Automatic blocking leaves global enable untouched
// [R5] Lock bits block interrupts in other section
// [R6] Unlock self-clears after four cycles or select
// [R7] Scan port enabled only if fuse, not disabled
// [R8] Scan disable needs same value twice in four
// [R9] Global pull-up off overrides pin pull-ups
// [R10] Reserved bits read zero, all reset zero
// [R11] Pins trigger even when driven as outputs
// [R12] Group0 eight masked toggles, group1 one input
// [R13] Higher change inputs and group2 do nothing
// [R14] Pin-change detection works without I/O clock
// [R15] Each pin: falling, rising or low level
// [R16] Level mode requests while pin stays low
// [R17] Upper edges need I/O clock, rest asynchronous
// [R18] I/O clock stops outside idle sleep mode
// [R19] Level wake without interrupt if level vanishes
// [R20] Pin interrupt needs global and mask enable
// [R21] Sense codes: low, any, falling, rising
// [R22] Flag cleared by writing one
// [R23] Captured requests pass two-stage synchronizer
module vspi_ctrl
  import vspi_pkg::*;
#(
  parameter int NPORT = 8  // Port pins with pull-up control
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  output logic [7:0] rdata_o,
  input wire logic [7:0] dedicated_irq_pins_i,
  input wire logic [8:0] pin_change_inputs_i,
  input wire logic io_clk_run_i,
  input wire logic global_irq_enable_i,
  input wire logic exec_in_boot_i,
  input wire logic app_section_lock_bit_i,
  input wire logic boot_section_lock_bit_i,
  input wire logic scan_port_fuse_i,
  input wire logic [NPORT-1:0] pin_direction_bit_i,
  input wire logic [NPORT-1:0] pin_output_bit_i,
  input wire logic [7:0] ext_irq_ack_i,
  input wire logic [1:0] pin_change_ack_i,
  output logic [7:0] ext_irq_req_o,
  output logic [1:0] pin_change_req_o,
  output logic irq_blocked_o,
  output logic wake_o,
  output logic vector_table_select_o,
  output logic scan_port_enable_o,
  output logic pullup_global_off_o,
  output logic [NPORT-1:0] pullup_enable_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] pin_s1;  // First synchronizer stage, dedicated pins
    logic [7:0] pin_s2;  // Second synchronizer stage
    logic [7:0] pin_last;  // Previous synchronized level
    logic [8:0] chg_s1;  // First stage, pin-change inputs
    logic [8:0] chg_s2;  // Second stage
    logic [8:0] chg_last;  // Previous synchronized level
    logic vsel;  // Vector table select
    logic unlock;  // Vector change unlock
    logic [2:0] unlock_cnt;  // Cycles left in unlock window
    logic [2:0] blk_cnt;  // Cycles of automatic blocking left
    logic scandis;  // Scan port disable
    logic scan_pend;  // First write of scan sequence seen
    logic scan_pend_val;  // Value of that first write
    logic [2:0] scan_cnt;  // Cycles left for second write
    logic puoff;  // Global pull-up off
    logic [15:0] sense;  // Two sense bits per pin
    logic [7:0] irq_mask;  // Dedicated pin enables
    logic [7:0] irq_flag;  // Dedicated pin edge flags
    logic [1:0] chg_en;  // Pin-change group enables
    logic [1:0] chg_flag;  // Pin-change group flags
    logic [7:0] chg_mask0;  // Group0 per-pin mask
    logic chg_mask1;  // Group1 single-pin mask
    logic [7:0] rdata;  // Read data, one cycle after strobe
  } vspi_state_t;

  vspi_state_t st;  // Registered state
  vspi_state_t next_st;  // Next state

  // ------------------------------------------------------------------
  // Edge match for one pin under its sense selection
  // ------------------------------------------------------------------
  function automatic logic vspi_edge_hit(input logic [1:0] sel,
                                         input logic cur,
                                         input logic prev);
    logic hit;
    hit = 1'b0;
    case (vspi_sense_t'(sel))  // R21
      VSPI_SENSE_ANY: hit = cur ^ prev;
      VSPI_SENSE_FALL: hit = prev & ~cur;
      VSPI_SENSE_RISE: hit = cur & ~prev;
      default: hit = 1'b0;  // Level mode keeps no flag
    endcase
    return hit;
  endfunction : vspi_edge_hit

  // ------------------------------------------------------------------
  // Combinational helpers
  // ------------------------------------------------------------------
  logic lock_block;  // Blocking from section lock bits
  logic auto_block;  // Blocking from vector change sequence
  logic gate;  // Interrupt delivery allowed
  logic [7:0] level_low;  // Enabled pins in level mode held low

  // Blocking only masks delivery; the global enable is never written
  always_comb
  begin
    lock_block = (st.vsel & app_section_lock_bit_i & ~exec_in_boot_i)
               | (~st.vsel & boot_section_lock_bit_i & exec_in_boot_i); // R5
    auto_block = st.unlock | (st.blk_cnt != 3'h0);  // R3
    gate = global_irq_enable_i & ~auto_block & ~lock_block;  // R4 R20
  end

  // Level requests follow the live synchronized pin, not a flag
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      level_low[i] = st.irq_mask[i] & ~st.pin_s2[i]
                   & (st.sense[2*i +: 2] == VSPI_SENSE_LOW);  // R16 R19
    end
  end

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb
  begin
    logic [7:0] edge_set;
    logic [1:0] chg_set;
    logic [8:0] toggle;
    logic [7:0] rval;
    next_st = st;
    edge_set = 8'h00;
    chg_set = 2'h0;
    toggle = 9'h000;
    rval = 8'h00;

    // Synchronizers: pad level counts even on output pins
    next_st.pin_s1 = dedicated_irq_pins_i;  // R11 R23
    next_st.pin_s2 = st.pin_s1;  // R23
    next_st.pin_last = st.pin_s2;
    next_st.chg_s1 = pin_change_inputs_i;  // R11 R23
    next_st.chg_s2 = st.chg_s1;  // R23
    next_st.chg_last = st.chg_s2;

    // Edge detection; upper four pins idle while I/O clock is off
    for (int i = 0; i < 8; i++)
    begin
      if (i < 4 || io_clk_run_i)  // R17 R18
      begin
        edge_set[i] = vspi_edge_hit(st.sense[2*i +: 2], st.pin_s2[i],
                                    st.pin_last[i]);  // R15
      end
    end

    // Pin-change toggles, independent of the I/O clock
    toggle = st.chg_s2 ^ st.chg_last;  // R14
    chg_set[0] = |(toggle[7:0] & st.chg_mask0);  // R12
    chg_set[1] = toggle[8] & st.chg_mask1;  // R12

    // A write on the fourth edge after arming still finds the window open
    // Timed windows count down
    if (st.unlock_cnt != 3'h0)
    begin
      next_st.unlock_cnt = st.unlock_cnt - 3'h1;
      if (st.unlock_cnt == 3'h1)
      begin
        next_st.unlock = 1'b0;  // R6
      end
    end
    if (st.blk_cnt != 3'h0)
    begin
      next_st.blk_cnt = st.blk_cnt - 3'h1;
    end
    if (st.scan_cnt != 3'h0)
    begin
      next_st.scan_cnt = st.scan_cnt - 3'h1;
      if (st.scan_cnt == 3'h1)
      begin
        next_st.scan_pend = 1'b0;
      end
    end

    // Flag clears: software write-one, core acknowledge
    if (wr_en_i && addr_i == VSPI_OFF_IRQ_FLAG)
    begin
      next_st.irq_flag = st.irq_flag & ~wdata_i;  // R22
    end
    if (wr_en_i && addr_i == VSPI_OFF_CHG_FLAG)
    begin
      next_st.chg_flag = st.chg_flag & ~wdata_i[1:0];  // R22
    end
    next_st.irq_flag = next_st.irq_flag & ~ext_irq_ack_i;
    next_st.chg_flag = next_st.chg_flag & ~pin_change_ack_i;

    // Register writes
    if (wr_en_i)
    begin
      case (addr_i)
        VSPI_OFF_GENERAL:
        begin
          next_st.puoff = wdata_i[VSPI_BIT_PUOFF];
          if (wdata_i[VSPI_BIT_UNLOCK])
          begin
            // Arming: start window and blocking together
            next_st.unlock = 1'b1;
            next_st.unlock_cnt = VSPI_WIN_CYCLES;  // R6
            next_st.blk_cnt = VSPI_WIN_CYCLES;  // R3
          end
          else if (st.unlock)
          begin
            // Select write inside the window
            next_st.vsel = wdata_i[VSPI_BIT_VSEL];  // R1 R2
            next_st.unlock = 1'b0;  // R6
            next_st.unlock_cnt = 3'h0;
            next_st.blk_cnt = VSPI_POST_SEL;  // R3
          end
          // Scan disable changes on a matching second write only
          if (wdata_i[VSPI_BIT_SCANDIS] != st.scandis)
          begin
            if (st.scan_pend &&
                st.scan_pend_val == wdata_i[VSPI_BIT_SCANDIS])
            begin
              next_st.scandis = wdata_i[VSPI_BIT_SCANDIS];  // R8
              next_st.scan_pend = 1'b0;
              next_st.scan_cnt = 3'h0;
            end
            else
            begin
              next_st.scan_pend = 1'b1;  // R8
              next_st.scan_pend_val = wdata_i[VSPI_BIT_SCANDIS];
              next_st.scan_cnt = VSPI_WIN_CYCLES;
            end
          end
          else
          begin
            // Writing the present value abandons a pending change
            next_st.scan_pend = 1'b0;
            next_st.scan_cnt = 3'h0;
          end
        end
        VSPI_OFF_SENSE_LOW: next_st.sense[7:0] = wdata_i;  // R15
        VSPI_OFF_SENSE_HIGH: next_st.sense[15:8] = wdata_i;  // R15
        VSPI_OFF_IRQ_MASK: next_st.irq_mask = wdata_i;  // R20
        VSPI_OFF_CHG_CTRL: next_st.chg_en = wdata_i[1:0];  // R13
        VSPI_OFF_CHG_MASK0: next_st.chg_mask0 = wdata_i;  // R12
        VSPI_OFF_CHG_MASK1: next_st.chg_mask1 = wdata_i[0];  // R13
        default: ;  // Unmapped and group2 mask: writes ignored
      endcase
    end

    // Hardware set wins over any clear in the same cycle
    next_st.irq_flag = next_st.irq_flag | edge_set;
    next_st.chg_flag = next_st.chg_flag | chg_set;

    // Register reads; reserved and unmapped bits read zero
    case (addr_i)
      VSPI_OFF_GENERAL:
        rval = {st.scandis, 2'h0, st.puoff, 2'h0,
                st.vsel, st.unlock};  // R10
      VSPI_OFF_SENSE_LOW: rval = st.sense[7:0];
      VSPI_OFF_SENSE_HIGH: rval = st.sense[15:8];
      VSPI_OFF_IRQ_MASK: rval = st.irq_mask;
      VSPI_OFF_IRQ_FLAG: rval = st.irq_flag;
      VSPI_OFF_CHG_CTRL: rval = {6'h00, st.chg_en};  // R13
      VSPI_OFF_CHG_FLAG: rval = {6'h00, st.chg_flag};  // R13
      VSPI_OFF_CHG_MASK0: rval = st.chg_mask0;
      VSPI_OFF_CHG_MASK1: rval = {7'h00, st.chg_mask1};  // R13
      default: rval = 8'h00;  // Group2 mask included
    endcase
    // Zero outside the slot, so a late sample by a master shows up at once
    next_st.rdata = rd_en_i ? rval : 8'h00;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Every field resets to zero
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      st <= '0;  // R10
    end
    else
    begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Level pins request directly, edge pins through their flag
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      ext_irq_req_o[i] = gate & (level_low[i]
                       | (st.irq_mask[i] & st.irq_flag[i]
                          & (st.sense[2*i +: 2] != VSPI_SENSE_LOW)));
    end
    // Pin-change groups also need their enable in the group control register
    pin_change_req_o = {2{gate}} & st.chg_flag & st.chg_en;
  end

  // Wake ignores the global enable; edges on upper pins excluded
  always_comb
  begin
    wake_o = (|level_low)
           | (|(st.irq_mask[3:0] & st.irq_flag[3:0]))
           | (|(st.chg_flag & st.chg_en));  // R14 R17 R19
  end

  assign rdata_o = st.rdata;
  // Blocked flag reports both causes; the core adds its own global enable
  assign irq_blocked_o = auto_block | lock_block;
  assign vector_table_select_o = st.vsel;  // R1
  // Fuse is taken live, so unprogramming it shuts the port at once
  assign scan_port_enable_o = scan_port_fuse_i & ~st.scandis;  // R7
  assign pullup_global_off_o = st.puoff;
  // Pull-up wanted when direction 0 and output 1, unless globally off
  assign pullup_enable_o = ~pin_direction_bit_i & pin_output_bit_i
                         & {NPORT{~st.puoff}};  // R9

endmodule : vspi_ctrl
